// File: src/pfdg_map.vh
`ifndef PFDG_MAP_VH
`define PFDG_MAP_VH

// Word addresses of the setup, key and status words
`define PFDG_ADDR_DELAY_SETUP 9'h100
`define PFDG_ADDR_MASK_KEY 9'h101
`define PFDG_ADDR_STATUS 9'h102
`define PFDG_ADDR_W 9

// Delay setting field
`define PFDG_DELAY_LSB 0
`define PFDG_DELAY_MSB 7
`define PFDG_DELAY_MAX 8'h0a
`define PFDG_DELAY_RESET 16'h0000

// Unlock pattern for the mask instruction
`define PFDG_KEY_UNLOCK 16'ha5a5
`define PFDG_KEY_RESET 16'h0000

// Times, in microseconds, and the clock in MHz
`define PFDG_AC_BASE_US 10000
`define PFDG_DC_BASE_US 2000
`define PFDG_AC_STEP_US 1000
`define PFDG_DC_STEP_US 200
`define PFDG_CLK_MHZ 25

// Status word bit positions
`define PFDG_ST_CONFIRMED 0
`define PFDG_ST_SUSPEND 1
`define PFDG_ST_DISPATCHED 2
`define PFDG_ST_HALTED 3

`endif

// File: src/pfdg_power_fail_guard.v
`timescale 1ns/100ps
`default_nettype none
`include "pfdg_map.vh"

module pfdg_power_fail_guard
#(
    parameter CNT_W = 20,
    parameter [CNT_W-1:0] AC_BASE_CYCLES = `PFDG_AC_BASE_US * `PFDG_CLK_MHZ,
    parameter [CNT_W-1:0] DC_BASE_CYCLES = `PFDG_DC_BASE_US * `PFDG_CLK_MHZ,
    parameter [15:0] AC_STEP_CYCLES = `PFDG_AC_STEP_US * `PFDG_CLK_MHZ,
    parameter [15:0] DC_STEP_CYCLES = `PFDG_DC_STEP_US * `PFDG_CLK_MHZ
)
(
    input wire clock,
    input wire arst_n,
    input wire supplyLow,
    input wire dcSupply,
    input wire powerOffTaskEnable,
    input wire suspendEnable,
    input wire maskInstr,
    input wire unmaskInstr,
    input wire cfgWrite,
    input wire [`PFDG_ADDR_W-1:0] cfgAddr,
    input wire [15:0] cfgWrData,
    output reg [15:0] cfgRdData,
    output reg powerFailConfirmed,
    output reg taskDispatch,
    output reg cpuReset,
    output reg cpuHalt,
    output reg suspendActive
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_BASE = 3'd1;
    localparam [2:0] ST_EXT = 3'd2;
    localparam [2:0] ST_HELD = 3'd3;
    localparam [2:0] ST_TASK = 3'd4;
    localparam [2:0] ST_HALT = 3'd5;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [15:0] delaySetup_reg;
    reg [15:0] maskKey_reg;
    reg suspend_reg;
    reg [CNT_W-1:0] baseCount_reg;
    reg [7:0] stepCount_reg;
    wire stepTick;
    wire [7:0] delayField;
    wire [7:0] delaySteps;
    wire [CNT_W-1:0] baseTarget;
    wire baseDone;
    wire extDone;
    reg [15:0] rdData_next;
    wire maskTake;
    wire suspend_next;

    // Write strobe aimed at one word address
    function writeHits;
        input strobe;
        input [`PFDG_ADDR_W-1:0] addr;
        input [`PFDG_ADDR_W-1:0] target;
        begin
            writeHits = strobe && (addr == target);
        end
    endfunction

    // A mask counts only with the key in place and before handling has begun;
    // once confirmed and unsuspended the dispatch is already committed
    function maskAccepted;
        input mask;
        input enable;
        input [15:0] key;
        input [2:0] state;
        begin
            maskAccepted = mask && enable && (key == `PFDG_KEY_UNLOCK)
                && (state < ST_HELD);
        end
    endfunction

    assign delayField = delaySetup_reg[`PFDG_DELAY_MSB:`PFDG_DELAY_LSB];
    assign delaySteps = (delayField > `PFDG_DELAY_MAX) ? `PFDG_DELAY_MAX : delayField;
    assign baseTarget = dcSupply ? DC_BASE_CYCLES : AC_BASE_CYCLES;
    assign baseDone = (baseCount_reg == baseTarget - {{(CNT_W-1){1'b0}}, 1'b1});
    assign extDone = (stepCount_reg >= delaySteps);
    assign maskTake = maskAccepted(maskInstr, suspendEnable, maskKey_reg, state_reg);
    assign suspend_next = unmaskInstr ? 1'b0 : (suspend_reg || maskTake);

    // step timebase restarts at base end
    pfdg_timebase #(
        .CNT_W(16),
        .AC_PERIOD(AC_STEP_CYCLES),
        .DC_PERIOD(DC_STEP_CYCLES)
    ) uTimebase (
        .clock(clock),
        .arst_n(arst_n),
        .restart(state_reg != ST_EXT),
        .dcMode(dcSupply),
        .tick(stepTick)
    );

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (supplyLow)
                    state_next = ST_BASE;
            end
            ST_BASE:
            begin
                if (!supplyLow)
                    state_next = ST_IDLE;
                else if (baseDone)
                    state_next = ST_EXT;
            end
            ST_EXT:
            begin
                if (!supplyLow)
                    state_next = ST_IDLE;
                else if (extDone)
                    state_next = ST_HELD;
            end
            ST_HELD:
            begin
                if (!suspend_reg || unmaskInstr)
                begin
                    if (powerOffTaskEnable)
                        state_next = ST_TASK;
                    else
                        state_next = ST_HALT;
                end
            end
            ST_TASK:
            begin
                state_next = ST_TASK;
            end
            ST_HALT:
            begin
                state_next = ST_HALT;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @*
    begin
        if (cfgAddr == `PFDG_ADDR_DELAY_SETUP)
            rdData_next = delaySetup_reg;
        else if (cfgAddr == `PFDG_ADDR_MASK_KEY)
            rdData_next = maskKey_reg;
        else if (cfgAddr == `PFDG_ADDR_STATUS)
            rdData_next = {12'h000, (state_next == ST_HALT), (state_next == ST_TASK),
                suspend_reg, (state_reg >= ST_HELD)};
        else
            rdData_next = 16'h0000;
    end

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= ST_IDLE;
            delaySetup_reg <= `PFDG_DELAY_RESET;
            maskKey_reg <= `PFDG_KEY_RESET;
            suspend_reg <= 1'b0;
            baseCount_reg <= {CNT_W{1'b0}};
            stepCount_reg <= 8'h00;
            cfgRdData <= 16'h0000;
            powerFailConfirmed <= 1'b0;
            taskDispatch <= 1'b0;
            cpuReset <= 1'b0;
            cpuHalt <= 1'b0;
            suspendActive <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cfgRdData <= rdData_next;
            if (writeHits(cfgWrite, cfgAddr, `PFDG_ADDR_DELAY_SETUP))
                delaySetup_reg <= cfgWrData;
            if (writeHits(cfgWrite, cfgAddr, `PFDG_ADDR_MASK_KEY))
                maskKey_reg <= cfgWrData;
            suspend_reg <= suspend_next;
            if (state_reg == ST_BASE)
                baseCount_reg <= baseCount_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            else
                baseCount_reg <= {CNT_W{1'b0}};
            if (state_reg != ST_EXT)
                stepCount_reg <= 8'h00;
            else if (stepTick)
                stepCount_reg <= stepCount_reg + 8'h01;
            powerFailConfirmed <= (state_next >= ST_HELD);
            taskDispatch <= (state_reg == ST_HELD) && (state_next == ST_TASK);
            cpuReset <= (state_reg == ST_HELD) && (state_next == ST_HALT);
            cpuHalt <= (state_next == ST_HALT);
            suspendActive <= suspend_next;
        end
    end
endmodule // pfdg_power_fail_guard

`default_nettype wire

// File: src/pfdg_timebase.v
`timescale 1ns/100ps
`default_nettype none
`include "pfdg_map.vh"

module pfdg_timebase
#(
    parameter CNT_W = 16,
    parameter [CNT_W-1:0] AC_PERIOD = 16'd25000,
    parameter [CNT_W-1:0] DC_PERIOD = 16'd5000
)
(
    input wire clock,
    input wire arst_n,
    input wire restart,
    input wire dcMode,
    output reg tick
);
    reg [CNT_W-1:0] count_reg;
    wire [CNT_W-1:0] period;

    assign period = dcMode ? DC_PERIOD : AC_PERIOD;

    // One-cycle tick every period, phase set by restart
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_reg <= {CNT_W{1'b0}};
            tick <= 1'b0;
        end
        else if (restart)
        begin
            count_reg <= {CNT_W{1'b0}};
            tick <= 1'b0;
        end
        else if (count_reg == period - {{(CNT_W-1){1'b0}}, 1'b1})
        begin
            count_reg <= {CNT_W{1'b0}};
            tick <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end
endmodule // pfdg_timebase

`default_nettype wire

// File: tb/pfdg_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pfdg_checker (
    input wire clock,
    input wire arst_n,
    input wire suspendEnable,
    input wire maskInstr,
    input wire unmaskInstr,
    input wire powerFailConfirmed,
    input wire taskDispatch,
    input wire cpuReset,
    input wire cpuHalt,
    input wire suspendActive
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    sequence s_act;
        taskDispatch || cpuReset;
    endsequence
    sequence s_release;
        suspendActive && unmaskInstr && powerFailConfirmed;
    endsequence
    a_confirm_acts:
        assert property ($rose(powerFailConfirmed) && !suspendActive |-> ##1 s_act)
        else $error("no action after confirmation");
    a_dispatch_confirmed:
        assert property (taskDispatch |-> powerFailConfirmed && !cpuReset)
        else $error("dispatch without confirmation");
    a_reset_halts:
        assert property (cpuReset |-> ##[0:1] cpuHalt)
        else $error("reset without halt");
    a_halt_sticky:
        assert property (cpuHalt |=> cpuHalt && !taskDispatch)
        else $error("halt released or task run");
    a_one_shot:
        assert property (s_act |=> !(taskDispatch || cpuReset) [*8])
        else $error("second action pulse");
    a_mask_gate:
        assert property ($rose(suspendActive) |-> $past(maskInstr && suspendEnable))
        else $error("suspension without mask");
    a_suspend_holds:
        assert property (suspendActive |-> !(taskDispatch || cpuReset))
        else $error("action while suspended");
    a_unmask_release:
        assert property (s_release |=> s_act ##0 !suspendActive)
        else $error("no action after unmask");
endmodule // pfdg_checker
bind pfdg_power_fail_guard pfdg_checker u_pfdg_checker (
    .clock(clock),
    .arst_n(arst_n),
    .suspendEnable(suspendEnable),
    .maskInstr(maskInstr),
    .unmaskInstr(unmaskInstr),
    .powerFailConfirmed(powerFailConfirmed),
    .taskDispatch(taskDispatch),
    .cpuReset(cpuReset),
    .cpuHalt(cpuHalt),
    .suspendActive(suspendActive)
);
`default_nettype wire

// File: tb/pfdg_supply_model.sv
`timescale 1ns/100ps
`default_nettype none
module pfdg_supply_model (
    input wire clock,
    output logic supplyLow,
    output logic maskInstr,
    output logic unmaskInstr
);
    initial
    begin
        supplyLow = 1'b0;
        maskInstr = 1'b0;
        unmaskInstr = 1'b0;
    end
    task set_low(input logic v);
        supplyLow = v;
    endtask
    // One-cycle instruction pulse from the sequencer
    task pulse(input logic unmask);
        maskInstr = !unmask;
        unmaskInstr = unmask;
        @(negedge clock);
        maskInstr = 1'b0;
        unmaskInstr = 1'b0;
    endtask
endmodule // pfdg_supply_model
`default_nettype wire

// File: tb/tb_power_fail_detect_guard.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfdg_map.vh"
module tb_power_fail_detect_guard;
    localparam int AC_BASE = 40, DC_BASE = 20, AC_STEP = 10, DC_STEP = 4;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic dcSupply = 1'b0;
    logic powerOffTaskEnable = 1'b0;
    logic suspendEnable = 1'b1;
    logic cfgWrite = 1'b0;
    logic [8:0] cfgAddr = 9'h000;
    logic [15:0] cfgWrData = 16'h0000;
    logic rdp = 1'b0;
    logic rdv = 1'b0;
    logic [15:0] v;
    logic [15:0] expQ[$];
    int seed = 32'hc773;
    int n_mismatch = 0;
    int checks = 0;
    wire supplyLow, maskInstr, unmaskInstr, powerFailConfirmed, taskDispatch;
    wire cpuReset, cpuHalt, suspendActive;
    wire [15:0] cfgRdData;
    pfdg_power_fail_guard #(
        .AC_BASE_CYCLES(20'(AC_BASE)),
        .DC_BASE_CYCLES(20'(DC_BASE)),
        .AC_STEP_CYCLES(16'(AC_STEP)),
        .DC_STEP_CYCLES(16'(DC_STEP))
    ) u_pfdg_power_fail_guard (
        .clock(clock),
        .arst_n(arst_n),
        .supplyLow(supplyLow),
        .dcSupply(dcSupply),
        .powerOffTaskEnable(powerOffTaskEnable),
        .suspendEnable(suspendEnable),
        .maskInstr(maskInstr),
        .unmaskInstr(unmaskInstr),
        .cfgWrite(cfgWrite),
        .cfgAddr(cfgAddr),
        .cfgWrData(cfgWrData),
        .cfgRdData(cfgRdData),
        .powerFailConfirmed(powerFailConfirmed),
        .taskDispatch(taskDispatch),
        .cpuReset(cpuReset),
        .cpuHalt(cpuHalt),
        .suspendActive(suspendActive)
    );
    pfdg_supply_model u_pfdg_supply_model (
        .clock(clock),
        .supplyLow(supplyLow),
        .maskInstr(maskInstr),
        .unmaskInstr(unmaskInstr)
    );
    always #20 clock = ~clock;
    always @(posedge clock) rdv <= rdp;
    // Oldest note against each read result or action pulse
    always @(negedge clock)
        if (rdv || taskDispatch || cpuReset)
        begin
            chk(expQ.size() > 0 && expQ[0] === (rdv ? cfgRdData : {14'h0, taskDispatch, cpuReset}));
            if (expQ.size() > 0) void'(expQ.pop_front());
        end
    task chk(input bit ok);
        checks++;
        if (!ok)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t mismatch", $time);
        end
    endtask
    task results;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task wr(input logic [8:0] a, input logic [15:0] d);
        cfgAddr = a;
        cfgWrData = d;
        cfgWrite = 1'b1;
        @(negedge clock);
        cfgWrite = 1'b0;
        @(negedge clock);
    endtask
    task rd(input logic [8:0] a, input logic [15:0] e);
        cfgAddr = a;
        expQ.push_back(e);
        rdp = 1'b1;
        @(negedge clock);
        rdp = 1'b0;
        @(negedge clock);
    endtask
    task run(input logic dc, input logic [15:0] s, input logic ten, input logic [15:0] key,
        input logic sen);
        int n;
        int e;
        bit sus;
        sus = (key == `PFDG_KEY_UNLOCK) && sen;
        u_pfdg_supply_model.set_low(1'b0);
        arst_n = 1'b0;
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        dcSupply = dc;
        powerOffTaskEnable = ten;
        suspendEnable = sen;
        wr(`PFDG_ADDR_DELAY_SETUP, s);
        wr(`PFDG_ADDR_MASK_KEY, key);
        u_pfdg_supply_model.pulse(1'b0);
        @(negedge clock);
        chk(suspendActive === sus);
        e = (dc ? DC_BASE : AC_BASE) + (s[7:0] > 10 ? 10 : s[7:0]) * (dc ? DC_STEP : AC_STEP) + 3;
        expQ.push_back(ten ? 16'h0002 : 16'h0001);
        // Short dip first: it must not count
        u_pfdg_supply_model.set_low(1'b1);
        repeat (5) @(negedge clock);
        u_pfdg_supply_model.set_low(1'b0);
        @(negedge clock);
        u_pfdg_supply_model.set_low(1'b1);
        n = 0;
        while (powerFailConfirmed !== 1'b1)
        begin
            @(negedge clock);
            n++;
            if (n > 500)
            begin
                n_mismatch++;
                results();
            end
        end
        chk(n >= e - 1 && n <= e + 3);
        if (sus)
        begin
            repeat (6) @(negedge clock);
            chk(expQ.size() == 1);
            u_pfdg_supply_model.pulse(1'b1);
        end
        repeat (4) @(negedge clock);
        chk(expQ.size() == 0 && cpuHalt === !ten);
        rd(`PFDG_ADDR_STATUS, {12'h000, !ten, ten, 2'b01});
    endtask
    initial
    begin
        repeat (6) @(negedge clock);
        arst_n = 1'b1;
        v = 16'($random(seed));
        rd(`PFDG_ADDR_DELAY_SETUP, `PFDG_DELAY_RESET);
        rd(`PFDG_ADDR_MASK_KEY, `PFDG_KEY_RESET);
        wr(`PFDG_ADDR_DELAY_SETUP, v);
        rd(`PFDG_ADDR_DELAY_SETUP, v);
        wr(9'h1ff, v);
        rd(9'h1ff, 16'h0000);
        rd(`PFDG_ADDR_STATUS, 16'h0000);
        run(1'b0, 16'h0000, 1'b1, 16'h0000, 1'b1);
        run(1'b1, v | 16'h0010, 1'b0, v | 16'h0002, 1'b1);
        run(1'b0, 16'h000a, 1'b1, 16'ha5a5, 1'b1);
        run(1'b1, 16'h0005, 1'b0, 16'ha5a5, 1'b1);
        run(1'b0, 16'h0003, 1'b0, 16'ha5a5, 1'b0);
        results();
    end
endmodule // tb_power_fail_detect_guard
`default_nettype wire
